/* File: inc/hsio_pkg.sv */
// Constants, register map and types of the high-speed I/O configuration bank
package hsio_pkg;

	// ************************************************************
	// Register byte addresses (one aligned word each)
	// ************************************************************
	localparam int             AW          = 8;
	localparam logic [AW-1:0] A_IN_SEL0   = 8'h00;
	localparam logic [AW-1:0] A_OUT_SEL0  = 8'h28;
	localparam logic [AW-1:0] A_CMODE0    = 8'h48;
	localparam logic [AW-1:0] A_CMODE3    = 8'h54;
	localparam logic [AW-1:0] A_FILT      = 8'h58;
	localparam logic [AW-1:0] A_GPO       = 8'h5C;
	localparam logic [AW-1:0] A_RUN       = 8'h60;
	localparam logic [AW-1:0] A_SPARE     = 8'h64;
	localparam logic [AW-1:0] A_GIE       = 8'h68;
	localparam logic [AW-1:0] A_IEN       = 8'h6C;
	localparam logic [AW-1:0] A_IMODE     = 8'h70;
	localparam logic [AW-1:0] A_ISTAT     = 8'h74;
	localparam logic [AW-1:0] A_IMASK     = 8'h78;

	// ************************************************************
	// Sizes and field layouts
	// ************************************************************
	localparam int         N_IN_SEL    = 10;
	localparam int         N_OUT       = 8;
	localparam int         N_CNT       = 8;
	localparam int         N_RUN       = 4;
	localparam int         N_FAST      = 16;
	localparam int         N_SRC       = 20;
	localparam int         N_EDGE_SRC  = 12;
	localparam int         N_PROBE     = 4;
	localparam int         N_EXT       = 8;
	localparam int         MEM_DEPTH   = N_IN_SEL + N_OUT;
	localparam int         MEM_AW      = 5;
	localparam int         CM_W        = 4;
	localparam int         EDGE_W      = 2;
	localparam int         ID_W        = 5;
	localparam logic [7:0] RUN_RD_MASK = 8'h3F;
	localparam logic [7:0] RST_BYTE    = 8'h00;

	// ************************************************************
	// Function and mode codes
	// ************************************************************
	localparam logic [7:0]        IN_PLAIN  = 8'h00;
	localparam logic [7:0]        IN_COUNT  = 8'h01;
	localparam logic [7:0]        IN_LATCH  = 8'h02;
	localparam logic [7:0]        IN_LIMIT  = 8'h03;
	localparam logic [7:0]        IN_PWIDTH = 8'h04;
	localparam logic [CM_W-1:0]   CM_SINGLE = 4'h0;
	localparam logic [CM_W-1:0]   CM_QUAD   = 4'h1;
	localparam logic [CM_W-1:0]   CM_TIMING = 4'h2;
	localparam logic [CM_W-1:0]   CM_DIRP   = 4'h3;
	localparam logic [7:0]        OUT_PLAIN = 8'h00;
	localparam logic [7:0]        OUT_PULSE = 8'h01;
	localparam logic [7:0]        OUT_CMP   = 8'h02;
	localparam logic [EDGE_W-1:0] EDGE_RISE = 2'h0;
	localparam logic [EDGE_W-1:0] EDGE_FALL = 2'h1;
	localparam logic [EDGE_W-1:0] EDGE_BOTH = 2'h2;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_NS        = 10;
	localparam int FILT_STEP_NS  = 250;
	localparam int FILT_STEP_CYC = (FILT_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PRE_W         = $clog2(FILT_STEP_CYC);

	typedef enum logic [1:0] {PH_IDLE, PH_ACC, PH_DONE} hsio_ph_t;
	typedef enum logic [2:0] {IF_PLAIN, IF_COUNT, IF_LATCH, IF_LIMIT, IF_PWIDTH} hsio_in_fn_t;
	typedef enum logic [1:0] {OF_PLAIN, OF_PULSE, OF_CMP, OF_RSVD} hsio_out_fn_t;

endpackage : hsio_pkg

/* File: rtl/hsio_cfg_mem.sv */
// Byte memory holding the input and output function selectors
module hsio_cfg_mem import hsio_pkg::*; #(
	parameter int DEPTH = MEM_DEPTH,
	parameter int ADW   = MEM_AW
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Write port
	input  wire logic               we,
	input  wire logic [ADW-1:0]     waddr,
	input  wire logic [7:0]         wdata,
	// Read port, one cycle latency
	input  wire logic [ADW-1:0]     raddr,
	output logic      [7:0]         rdata,
	// All bytes in parallel
	output logic      [DEPTH*8-1:0] contents
);

	if (DEPTH < 1 || DEPTH > (1 << ADW)) begin : g_chk
		$error("hsio_cfg_mem: DEPTH does not fit the address width");
	end

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [7:0]            rdata;
	} hsio_mem_st_t;

	hsio_mem_st_t s_q;
	hsio_mem_st_t s_d;

	always_comb begin
		s_d       = s_q;
		s_d.rdata = (32'(raddr) < DEPTH) ? s_q.mem[raddr] : RST_BYTE;
		if (we && 32'(waddr) < DEPTH) begin
			s_d.mem[waddr] = wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata    = s_q.rdata;
	assign contents = s_q.mem;

endmodule : hsio_cfg_mem

/* File: rtl/hsio_cfg_map.sv */
// High-speed I/O configuration bank with APB slave, filter, outputs and interrupts
// Notes on behaviour
// - Per-input selector, code 4 is pulse width
// - Codes 0-3: plain, count, latch, limit
// - Two counting channels per byte, even low nibble
// - Mode 0 single, 1 quadrature, 2 timing, 3 direction
// - Filter byte counts quarter-microsecond steps
// - Output selector: 0 plain, 2 compare, 3+ reserved
// - Compare output high while counter equals value
// - General output byte drives plain outputs
// - Run bits 0 to 3 gate pulse outputs in pairs, bit n gates 2n and 2n+1
// - Enable word bit n enables source n
// - Mode word holds two-bit edge fields
// - Edge code 0 rise, 1 fall, 2 both
module hsio_cfg_map import hsio_pkg::*; #(
	parameter int CNT_W = 32
) (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [AW-1:0]          paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic      [31:0]            prdata,
	output logic                        pslverr,
	// Interrupt
	output logic                        irq,
	output logic                        irq_event,
	output logic      [ID_W-1:0]        irq_event_id,
	// Input pins and filtered levels
	input  wire logic [N_FAST-1:0]      fast_in,
	input  wire logic [N_PROBE-1:0]     probe_in,
	input  wire logic [N_EXT-1:0]       ext_src_in,
	output logic      [N_FAST-1:0]      fast_in_filt,
	// Decoded functions of inputs 6 to 15
	output logic      [N_IN_SEL-1:0]    in_fn_count,
	output logic      [N_IN_SEL-1:0]    in_fn_latch,
	output logic      [N_IN_SEL-1:0]    in_fn_limit,
	output logic      [N_IN_SEL-1:0]    in_fn_pwidth,
	// Decoded counting modes per channel
	output logic      [N_CNT-1:0]       cnt_single,
	output logic      [N_CNT-1:0]       cnt_quad,
	output logic      [N_CNT-1:0]       cnt_timing,
	output logic      [N_CNT-1:0]       cnt_dirp,
	// Counter and pulse datapath
	input  wire logic [N_CNT*CNT_W-1:0] cnt_value,
	input  wire logic [N_CNT*CNT_W-1:0] cmp_value,
	input  wire logic [N_OUT-1:0]       pulse_drive,
	output logic      [N_RUN-1:0]       run_en,
	// Output pins
	output logic      [N_OUT-1:0]       y_out
);

	if (CNT_W < 1 || CNT_W > 32) begin : g_chk
		$error("hsio_cfg_map: CNT_W must lie in 1..32");
	end

	// ************************************************************
	// Decoders
	// ************************************************************
	function automatic hsio_in_fn_t in_fn(input logic [7:0] code);
		case (code)
			IN_COUNT:  in_fn = IF_COUNT;
			IN_LATCH:  in_fn = IF_LATCH;
			IN_LIMIT:  in_fn = IF_LIMIT;
			IN_PWIDTH: in_fn = IF_PWIDTH;
			default:   in_fn = IF_PLAIN;
		endcase
	endfunction : in_fn

	function automatic hsio_out_fn_t out_fn(input logic [7:0] code);
		case (code)
			OUT_PLAIN: out_fn = OF_PLAIN;
			OUT_PULSE: out_fn = OF_PULSE;
			OUT_CMP:   out_fn = OF_CMP;
			default:   out_fn = OF_RSVD;
		endcase
	endfunction : out_fn

	function automatic logic edge_hit(input logic [EDGE_W-1:0] mode,
		input logic prev, input logic cur);
		case (mode)
			EDGE_RISE: edge_hit = !prev && cur;
			EDGE_FALL: edge_hit = prev && !cur;
			EDGE_BOTH: edge_hit = prev ^ cur;
			default:   edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// Even channel of the counting mode byte at this address
	function automatic logic [2:0] cm_even(input logic [AW-1:0] a);
		cm_even = 3'((a - A_CMODE0) >> 1);
	endfunction : cm_even

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		hsio_ph_t                  ph;
		logic [31:0]               rdata;
		logic                      slverr;
		logic [N_CNT-1:0][CM_W-1:0] cmode;
		logic [7:0]                filt;
		logic [7:0]                gpo;
		logic [7:0]                run;
		logic                      gie;
		logic [N_SRC-1:0]          ien;
		logic [N_EDGE_SRC-1:0][EDGE_W-1:0] imode;
		logic [N_SRC-1:0]          ist;
		logic [N_SRC-1:0]          imask;
		logic [PRE_W-1:0]          pre;
		logic [N_FAST-1:0]         flt;
		logic [N_FAST-1:0][7:0]    stab;
		logic [N_SRC-1:0]          prev;
		logic                      evt;
		logic [ID_W-1:0]           evt_id;
		logic [N_OUT-1:0]          y;
		logic [N_IN_SEL-1:0]       f_cnt;
		logic [N_IN_SEL-1:0]       f_lat;
		logic [N_IN_SEL-1:0]       f_lim;
		logic [N_IN_SEL-1:0]       f_pw;
		logic [N_CNT-1:0]          c_sgl;
		logic [N_CNT-1:0]          c_quad;
		logic [N_CNT-1:0]          c_tim;
		logic [N_CNT-1:0]          c_dir;
	} hsio_st_t;

	hsio_st_t                 s_q;
	hsio_st_t                 s_d;
	logic                     mem_we;
	logic [7:0]               mem_rdata;
	logic [MEM_DEPTH*8-1:0]   mem_all;
	logic                     mem_hit;
	logic                     done;
	logic [N_SRC-1:0]         src_now;
	logic [N_SRC-1:0]         hits;
	logic                     tick;

	assign mem_hit = (paddr[1:0] == 2'h0) && (32'(paddr[AW-1:2]) < MEM_DEPTH);
	assign done    = psel && penable && (s_q.ph == PH_DONE);
	assign mem_we  = done && pwrite && mem_hit;
	assign tick    = (s_q.pre == PRE_W'(FILT_STEP_CYC - 1));

	// ************************************************************
	// Selector memory
	// ************************************************************
	hsio_cfg_mem #(
		.DEPTH (MEM_DEPTH),
		.ADW   (MEM_AW)
	) u_sel_mem (
		.clk      (pclk),
		.rst_n    (presetn),
		.we       (mem_we),
		.waddr    (paddr[MEM_AW+1:2]),
		.wdata    (pwdata[7:0]),
		.raddr    (paddr[MEM_AW+1:2]),
		.rdata    (mem_rdata),
		.contents (mem_all)
	);

	// ************************************************************
	// Interrupt sources and edges
	// ************************************************************
	always_comb begin
		src_now = {ext_src_in, probe_in, s_q.flt[N_OUT-1:0]};
		hits    = '0;
		for (int i = 0; i < N_SRC; i++) begin
			if (i < N_EDGE_SRC) begin
				hits[i] = edge_hit(s_q.imode[i], s_q.prev[i], src_now[i]);
			end else begin
				hits[i] = edge_hit(EDGE_RISE, s_q.prev[i], src_now[i]);
			end
			hits[i] = hits[i] && s_q.ien[i] && s_q.gie;
		end
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d = s_q;

		// APB phases: one wait cycle, read data latched in it
		case (s_q.ph)
			PH_IDLE: begin
				if (psel && penable) begin
					s_d.ph = PH_DONE;
				end
				s_d.slverr = 1'b0;
				s_d.rdata  = '0;
				if (psel && penable) begin
					s_d.slverr = 1'b1;
					if (paddr[1:0] == 2'h0) begin
						s_d.slverr = 1'b0;
						if (mem_hit) begin
							s_d.rdata = {24'h0, mem_rdata};
						end else if (paddr >= A_CMODE0 && paddr <= A_CMODE3) begin
							s_d.rdata = {24'h0, s_q.cmode[cm_even(paddr) | 3'h1],
								s_q.cmode[cm_even(paddr)]};
						end else begin
							case (paddr)
								A_FILT:  s_d.rdata = {24'h0, s_q.filt};
								A_GPO:   s_d.rdata = {24'h0, s_q.gpo};
								A_RUN:   s_d.rdata = {24'h0, s_q.run & RUN_RD_MASK};
								A_SPARE: s_d.rdata = '0;
								A_GIE:   s_d.rdata = {31'h0, s_q.gie};
								A_IEN:   s_d.rdata = {12'h0, s_q.ien};
								A_IMODE: s_d.rdata = {8'h0, s_q.imode};
								A_ISTAT: s_d.rdata = {12'h0, s_q.ist};
								A_IMASK: s_d.rdata = {12'h0, s_q.imask};
								default: s_d.slverr = 1'b1;
							endcase
						end
					end
					if (pwrite) begin
						s_d.rdata = '0;
					end
				end
			end
			PH_DONE: begin
				s_d.ph = PH_IDLE;
			end
			default: begin
				s_d.ph = PH_IDLE;
			end
		endcase

		// Writes take effect at the completing edge
		if (done && pwrite && !s_q.slverr) begin
			if (paddr >= A_CMODE0 && paddr <= A_CMODE3) begin
				s_d.cmode[cm_even(paddr)]        = pwdata[CM_W-1:0];
				s_d.cmode[cm_even(paddr) | 3'h1] = pwdata[2*CM_W-1:CM_W];
			end else begin
				case (paddr)
					A_FILT:  s_d.filt  = pwdata[7:0];
					A_GPO:   s_d.gpo   = pwdata[7:0];
					A_RUN:   s_d.run   = pwdata[7:0] & RUN_RD_MASK;
					A_GIE:   s_d.gie   = pwdata[0];
					A_IEN:   s_d.ien   = pwdata[N_SRC-1:0];
					A_IMODE: s_d.imode = pwdata[N_EDGE_SRC*EDGE_W-1:0];
					A_IMASK: s_d.imask = pwdata[N_SRC-1:0];
					default: s_d.gie   = s_q.gie;
				endcase
			end
		end

		// Sticky status: read clears, a new event in that cycle wins
		// Only bits already returned are cleared, so a late event survives
		if (done && !pwrite && paddr == A_ISTAT) begin
			s_d.ist = (s_q.ist & ~s_q.rdata[N_SRC-1:0]) | hits;
		end else begin
			s_d.ist = s_q.ist | hits;
		end

		// Event pulse naming the lowest active source
		s_d.evt    = |hits;
		s_d.evt_id = '0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (hits[i]) begin
				s_d.evt_id = ID_W'(i);
			end
		end
		s_d.prev = src_now;

		// Input filter: level must hold filt steps of 0.25 us
		s_d.pre = tick ? '0 : s_q.pre + 1'b1;
		for (int i = 0; i < N_FAST; i++) begin
			if (fast_in[i] == s_q.flt[i]) begin
				s_d.stab[i] = '0;
			end else if (s_q.stab[i] >= s_q.filt) begin
				s_d.flt[i]  = fast_in[i];
				s_d.stab[i] = '0;
			end else if (tick) begin
				s_d.stab[i] = s_q.stab[i] + 1'b1;
			end
		end

		// Input function decode
		for (int i = 0; i < N_IN_SEL; i++) begin
			s_d.f_cnt[i] = in_fn(mem_all[8*i +: 8]) == IF_COUNT;
			s_d.f_lat[i] = in_fn(mem_all[8*i +: 8]) == IF_LATCH;
			s_d.f_lim[i] = in_fn(mem_all[8*i +: 8]) == IF_LIMIT;
			s_d.f_pw[i]  = in_fn(mem_all[8*i +: 8]) == IF_PWIDTH;
		end

		// Counting mode decode
		for (int c = 0; c < N_CNT; c++) begin
			s_d.c_sgl[c]  = s_q.cmode[c] == CM_SINGLE;
			s_d.c_quad[c] = s_q.cmode[c] == CM_QUAD;
			s_d.c_tim[c]  = s_q.cmode[c] == CM_TIMING;
			s_d.c_dir[c]  = s_q.cmode[c] == CM_DIRP;
		end

		// Output pins per selected function
		for (int o = 0; o < N_OUT; o++) begin
			case (out_fn(mem_all[8*(N_IN_SEL+o) +: 8]))
				OF_PLAIN: s_d.y[o] = s_q.gpo[o];
				OF_PULSE: s_d.y[o] = pulse_drive[o] && s_q.run[o/2];
				OF_CMP:   s_d.y[o] = cnt_value[CNT_W*o +: CNT_W] ==
					cmp_value[CNT_W*o +: CNT_W];
				default:  s_d.y[o] = 1'b0;
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign pready       = psel && penable && (s_q.ph == PH_DONE);
	assign prdata       = s_q.rdata;
	assign pslverr      = pready && s_q.slverr;
	assign irq          = |(s_q.ist & s_q.imask);
	assign irq_event    = s_q.evt;
	assign irq_event_id = s_q.evt_id;
	assign fast_in_filt = s_q.flt;
	assign in_fn_count  = s_q.f_cnt;
	assign in_fn_latch  = s_q.f_lat;
	assign in_fn_limit  = s_q.f_lim;
	assign in_fn_pwidth = s_q.f_pw;
	assign cnt_single   = s_q.c_sgl;
	assign cnt_quad     = s_q.c_quad;
	assign cnt_timing   = s_q.c_tim;
	assign cnt_dirp     = s_q.c_dir;
	assign run_en       = s_q.run[N_RUN-1:0];
	assign y_out        = s_q.y;

endmodule : hsio_cfg_map

/* File: bench/hsio_cfg_asserts.sv */
// Port-level checks of the configuration bank
module hsio_cfg_asserts import hsio_pkg::*; (
	// Clock and reset
	input wire logic                pclk,
	input wire logic                presetn,
	// APB
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [AW-1:0]       paddr,
	input wire logic [31:0]         pwdata,
	input wire logic                pready,
	input wire logic [31:0]         prdata,
	input wire logic                pslverr,
	// Watched outputs
	input wire logic                irq_event,
	input wire logic [ID_W-1:0]     irq_event_id,
	input wire logic [N_IN_SEL-1:0] in_fn_count,
	input wire logic [N_IN_SEL-1:0] in_fn_latch,
	input wire logic [N_IN_SEL-1:0] in_fn_pwidth,
	input wire logic [N_CNT-1:0]    cnt_quad,
	input wire logic [N_RUN-1:0]    run_en
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***
	// Last written word
	// ***
	logic [31:0] wd_q;
	logic        done;
	assign done = psel && penable && pready && pwrite;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			wd_q <= 32'h0;
		else if (done)
			wd_q <= pwdata;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_apb_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_bad_addr_err: assert property (psel && penable && pready &&
		(paddr > A_IMASK || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("bad address not refused");
	a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside completion");
	a_write_rdata_zero: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("read data on write");
	a_run_gate_load: assert property (done && paddr == A_RUN |-> ##1 run_en == wd_q[3:0])
		else $error("run gate not loaded");
	a_pwidth_decode: assert property (done && paddr == A_IN_SEL0 |->
		##2 in_fn_pwidth[0] == (wd_q[7:0] == IN_PWIDTH))
		else $error("pulse width decode wrong");
	a_quad_decode: assert property (done && paddr == A_CMODE0 |->
		##2 cnt_quad[1] == (wd_q[7:4] == CM_QUAD))
		else $error("odd channel mode decode wrong");
	a_fn_exclusive: assert property ((in_fn_count & in_fn_latch) == 0 &&
		(in_fn_latch & in_fn_pwidth) == 0)
		else $error("input functions overlap");
	a_event_id_range: assert property (irq_event |-> irq_event_id < N_SRC)
		else $error("event number out of range");
endmodule : hsio_cfg_asserts

/* File: bench/hsio_apb_host.sv */
// Controller-side APB master model
module hsio_apb_host import hsio_pkg::*; (
	// Clock
	input  wire logic        pclk,
	// APB
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [AW-1:0]    paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
	end
	// One transfer, entered just after a rising edge; to is set on no answer
	task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output bit to);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		to = (n >= 20);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
endmodule : hsio_apb_host

/* File: bench/testbench.sv */
// Self-checking bench of the configuration bank
module testbench import hsio_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CW = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq, irq_event, e;
	logic [AW-1:0] paddr;
	logic [31:0] pwdata, prdata, cv, cm, q;
	logic [ID_W-1:0] irq_event_id, ev_id;
	logic [N_FAST-1:0] fast_in = 16'h0, fast_in_filt;
	logic [N_PROBE-1:0] probe_in = 4'h0;
	logic [7:0] ext_src_in = 8'h0, pulse_drive = 8'h0, y_out, gpo, run, pd, ey;
	logic [N_IN_SEL-1:0] in_fn_count, in_fn_latch, in_fn_limit, in_fn_pwidth;
	logic [N_CNT-1:0] cnt_single, cnt_quad, cnt_timing, cnt_dirp;
	logic [N_CNT*CW-1:0] cnt_value = 32'h0, cmp_value = 32'h0;
	logic [N_RUN-1:0] run_en;
	int err_count = 0, compares = 0, ev_n = 0, n, s, k, c;
	// Source, edge code, global gate, enable, mask, events expected
	int cs [8][6] = '{'{0, 0, 1, 1, 1, 1}, '{3, 1, 1, 1, 1, 1}, '{9, 2, 1, 1, 1, 2},
		'{15, 0, 1, 1, 1, 1}, '{5, 3, 1, 1, 1, 0}, '{2, 0, 0, 1, 1, 0},
		'{4, 2, 1, 0, 1, 0}, '{6, 0, 1, 1, 0, 1}};
	always #5 pclk = ~pclk;
	always @(posedge pclk)
		if (irq_event === 1'b1) begin
			ev_n++;
			ev_id = irq_event_id;
		end

	hsio_cfg_map #(.CNT_W(CW)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
		.irq_event(irq_event), .irq_event_id(irq_event_id), .fast_in(fast_in),
		.probe_in(probe_in), .ext_src_in(ext_src_in), .fast_in_filt(fast_in_filt),
		.in_fn_count(in_fn_count), .in_fn_latch(in_fn_latch), .in_fn_limit(in_fn_limit),
		.in_fn_pwidth(in_fn_pwidth), .cnt_single(cnt_single), .cnt_quad(cnt_quad),
		.cnt_timing(cnt_timing), .cnt_dirp(cnt_dirp), .cnt_value(cnt_value),
		.cmp_value(cmp_value), .pulse_drive(pulse_drive), .run_en(run_en), .y_out(y_out));
	hsio_apb_host h_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));

	// ***
	// Reporting, bus access, expectations
	// ***
	task automatic end_of_test();
		$display("counts: %0d compares, %0d mismatches", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
		compares++;
		if (g !== x) begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, x);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic er);
		bit to;
		h_u.xfer(1'b0, a, 32'h0, d, er, to);
		if (to) begin
			err_count++;
			end_of_test();
		end
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dq;
		logic        de;
		bit          to_w;
		h_u.xfer(1'b1, a, d, dq, de, to_w);
		if (to_w) begin
			err_count++;
			end_of_test();
		end
	endtask : wr
	task automatic src(input int sn, input logic v);
		if (sn < 8)
			fast_in[sn] <= v;
		else if (sn < 12)
			probe_in[sn-8] <= v;
		else
			ext_src_in[sn-12] <= v;
	endtask : src
	function automatic logic [31:0] rmask(input logic [7:0] a);
		case (a)
			A_RUN: return 32'h3F;
			A_SPARE, A_ISTAT: return 32'h0;
			A_GIE: return 32'h1;
			A_IEN, A_IMASK: return 32'hFFFFF;
			A_IMODE: return 32'hFFFFFF;
			default: return 32'hFF;
		endcase
	endfunction : rmask
	function automatic logic y_exp(input int cd, input int o);
		case (cd)
			0: return gpo[o];
			1: return pd[o] & run[o/2];
			2: return cv[4*o+:4] == cm[4*o+:4];
			default: return 1'b0;
		endcase
	endfunction : y_exp
	function automatic logic [31:0] fn_of(input int i);
		return {28'h0, in_fn_pwidth[i], in_fn_limit[i], in_fn_latch[i], in_fn_count[i]};
	endfunction : fn_of
	function automatic logic [31:0] cm_of(input int i);
		return {28'h0, cnt_dirp[i], cnt_timing[i], cnt_quad[i], cnt_single[i]};
	endfunction : cm_of

	initial begin
		n = $urandom(32'hC2F4A01B);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a <= A_IMASK; a += 4) begin
			rd(8'(a), q, e);
			chk(q, 32'h0, "reset value");
			cv = $urandom;
			wr(8'(a), cv);
			rd(8'(a), q, e);
			chk(q, cv & rmask(8'(a)), "read back");
		end
		rd(8'h7C, q, e);
		chk({31'h0, e}, 32'h1, "unmapped");
		rd(8'h06, q, e);
		chk({31'h0, e}, 32'h1, "unaligned");
		chk(q, 32'h0, "error data");
		$display("test registers done");
		wr(A_GIE, 32'h0);
		wr(A_FILT, 32'h0);
		fast_in <= 16'h00F0;
		repeat (3) @(posedge pclk);
		chk({16'h0, fast_in_filt}, 32'h00F0, "unfiltered");
		wr(A_FILT, 32'h2);
		fast_in <= 16'h00F1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (fast_in_filt[0] !== 1'b1 && n < 100);
		chk({31'h0, n >= 25 && n <= 55}, 32'h1, "filter delay");
		wr(A_FILT, 32'h0);
		fast_in <= 16'h0;
		$display("test filter done");
		for (int i = 0; i <= 5; i++) begin
			k = $urandom_range(9);
			wr(A_IN_SEL0 + 8'(4 * k), i == 5 ? $urandom_range(255, 5) : i);
			repeat (2) @(posedge pclk);
			chk(fn_of(k), i inside {[1:4]} ? 32'h1 << (i - 1) : 32'h0, "in fn");
			r_cm(i);
		end
		$display("test decode done");
		for (int i = 0; i < 4; i++) begin
			gpo = $urandom;
			run = $urandom;
			pd = $urandom;
			cv = $urandom;
			cm = cv ^ ($urandom & 32'hF0F0F0F0);
			pulse_drive <= pd;
			cnt_value <= cv;
			cmp_value <= cm;
			wr(A_GPO, {24'h0, gpo});
			wr(A_RUN, {24'h0, run});
			for (int o = 0; o < 8; o++) begin
				c = (o + i) % 4;
				wr(A_OUT_SEL0 + 8'(4 * o), c == 3 ? $urandom_range(255, 3) : c);
				ey[o] = y_exp(c, o);
			end
			repeat (3) @(posedge pclk);
			chk({24'h0, y_out}, {24'h0, ey}, "outputs");
			chk({28'h0, run_en}, {28'h0, run[3:0]}, "run gate");
		end
		$display("test outputs done");
		foreach (cs[i]) begin
			s = cs[i][0];
			wr(A_GIE, 32'(cs[i][2]));
			wr(A_IEN, 32'(cs[i][3]) << s);
			wr(A_IMODE, 32'(cs[i][1]) << (2 * s));
			wr(A_IMASK, 32'(cs[i][4]) << s);
			rd(A_ISTAT, q, e);
			ev_n = 0;
			src(s, 1'b1);
			repeat (5) @(posedge pclk);
			src(s, 1'b0);
			repeat (5) @(posedge pclk);
			chk(32'(ev_n), 32'(cs[i][5]), "events");
			if (cs[i][5] > 0)
				chk({27'h0, ev_id}, 32'(s), "event id");
			chk({31'h0, irq}, 32'(cs[i][4] == 1 && cs[i][5] > 0), "irq level");
			rd(A_ISTAT, q, e);
			chk({31'h0, q[s]}, 32'(cs[i][5] > 0), "status");
			repeat (2) @(posedge pclk);
			chk({31'h0, irq}, 32'h0, "irq cleared");
		end
		$display("test interrupts done");
		end_of_test();
	end
	// Count modes for a random byte, even channel low nibble
	task automatic r_cm(input int i);
		int r;
		if (i < 4) begin
			r = $urandom_range(3);
			wr(A_CMODE0 + 8'(4 * r), {24'h0, 4'(3 - i), 4'(i)});
			repeat (2) @(posedge pclk);
			chk(cm_of(2 * r), 32'h1 << i, "even mode");
			chk(cm_of(2 * r + 1), 32'h1 << (3 - i), "odd mode");
		end
	endtask : r_cm
endmodule : testbench

bind hsio_cfg_map hsio_cfg_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .irq_event(irq_event),
	.irq_event_id(irq_event_id), .in_fn_count(in_fn_count), .in_fn_latch(in_fn_latch),
	.in_fn_pwidth(in_fn_pwidth), .cnt_quad(cnt_quad), .run_en(run_en));
